// ---- rtl/system_bus_master_sequencer.sv ----
// system bus master sequencer: single and burst transfers, physical or virtual
// Behaviour
// - assert bus request; wait for grant before leaving the request phase
// - physical mode: reach physical address phase within three clocks of grant
// - address phase drives address, strobe, direction, size; drops request unless more
// - single read: strobe off, data enable on, latch data on valid acknowledge
// - data phase extends while acknowledge withheld; advance only on acknowledge
// - single write: strobe off, data enable on, drive write data, sample ack
// - each burst data phase asserts data enable; each but the last advances the upper address
// - burst is four or eight data phases per configured size
// - early-negate bit 0: strobe off in last burst phase; 1: in first
// - burst read latches a word only on a valid acknowledge
// - virtual mode: enter virtual address phase within three clocks of grant
// - virtual phase: one clock, strobe negated, size driven, direction by read
// - recovery phase after last data phase, then outputs released
// - retry in data phase: recovery, rerun whole transaction on new grant
// - idle: drive no bus signal; request may be raised when needed
`timescale 1ns/10ps
module system_bus_master_sequencer (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_virtual_mode,
  input wire logic i_strobe_early_negate,
  input wire logic i_req_valid,
  input wire bus_seq_pkg::xfer_req_t i_req,
  input wire logic i_more_pending,
  input wire logic [bus_seq_pkg::DATA_W-1:0] i_wr_data,
  input wire bus_seq_pkg::bus_in_t i_bus,
  input wire logic [bus_seq_pkg::DATA_W-1:0] i_muxed_addr_data_lines,
  output logic o_req_ready,
  output logic o_wr_data_take,
  output logic o_rd_valid,
  output logic [bus_seq_pkg::DATA_W-1:0] o_rd_data,
  output logic o_done,
  output logic o_error,
  output logic o_bus_request_n,
  output logic o_bus_request_n_oe,
  output logic [bus_seq_pkg::ADDR_W-1:0] o_upper_address_lines,
  output logic o_upper_address_lines_oe,
  output logic [bus_seq_pkg::DATA_W-1:0] o_muxed_addr_data_lines,
  output logic o_muxed_addr_data_lines_oe,
  output logic o_address_strobe_n,
  output logic o_address_strobe_n_oe,
  output logic o_read_not_write,
  output logic [bus_seq_pkg::SIZE_W-1:0] o_transfer_size,
  output logic o_data_enable_n,
  output logic o_ctrl_oe
);
  bus_seq_pkg::seq_state_t state_r, state_nxt;
  bus_seq_pkg::xfer_req_t cur_r, cur_nxt;
  logic [3:0] left_r, left_nxt;
  logic first_r, first_nxt;
  logic [bus_seq_pkg::ADDR_W-1:0] addr_r, addr_nxt;
  logic [bus_seq_pkg::DATA_W-1:0] ad_r, ad_nxt, rd_r, rd_nxt;
  logic br_r, br_nxt, as_r, as_nxt, den_r, den_nxt, rw_r, rw_nxt;
  logic aoe_r, aoe_nxt, adoe_r, adoe_nxt, asoe_r, asoe_nxt, coe_r, coe_nxt, broe_r, broe_nxt;
  logic [bus_seq_pkg::SIZE_W-1:0] siz_r, siz_nxt;
  logic rdv_r, rdv_nxt, done_r, done_nxt, err_r, err_nxt, rdy_r, rdy_nxt, take_r, take_nxt;
  logic ack, err, retry, grant, last;

  assign grant = !i_bus.bus_grant_n;
  assign ack = !i_bus.slave_acknowledge_n;
  assign err = !i_bus.slave_error_n;
  assign retry = !i_bus.retry_n;
  assign last = (left_r == 4'h1);

  always_comb begin
    state_nxt = state_r;
    cur_nxt = cur_r;
    left_nxt = left_r;
    first_nxt = first_r;
    addr_nxt = addr_r;
    ad_nxt = ad_r;
    rd_nxt = rd_r;
    br_nxt = br_r;
    as_nxt = as_r;
    den_nxt = den_r;
    rw_nxt = rw_r;
    siz_nxt = siz_r;
    aoe_nxt = aoe_r;
    adoe_nxt = adoe_r;
    asoe_nxt = asoe_r;
    coe_nxt = coe_r;
    broe_nxt = broe_r;
    rdv_nxt = 1'b0;
    done_nxt = 1'b0;
    err_nxt = 1'b0;
    take_nxt = 1'b0;
    rdy_nxt = 1'b0;
    unique case (state_r)
      bus_seq_pkg::ST_IDLE: begin
        // all lines released while idle
        aoe_nxt = 1'b0;
        adoe_nxt = 1'b0;
        asoe_nxt = 1'b0;
        coe_nxt = 1'b0;
        rdy_nxt = !i_req_valid;
        if (i_req_valid) begin
          cur_nxt = i_req;
          br_nxt = 1'b0;
          broe_nxt = 1'b1;
          state_nxt = bus_seq_pkg::ST_REQ;
        end else begin
          br_nxt = 1'b1;
          broe_nxt = 1'b0;
        end
      end
      bus_seq_pkg::ST_REQ: begin
        // leave only on grant; one clock later address phase starts
        if (grant) begin
          addr_nxt = cur_r.addr;
          ad_nxt = cur_r.addr;
          first_nxt = 1'b1;
          left_nxt = !cur_r.burst ? 4'h1 :
                     (cur_r.burst8 ? bus_seq_pkg::BURST_LONG : bus_seq_pkg::BURST_SHORT);
          siz_nxt = !cur_r.burst ? bus_seq_pkg::SIZE_SINGLE :
                    (cur_r.burst8 ? bus_seq_pkg::SIZE_BURST8 : bus_seq_pkg::SIZE_BURST4);
          rw_nxt = cur_r.read;
          aoe_nxt = 1'b1;
          adoe_nxt = 1'b1;
          asoe_nxt = 1'b1;
          coe_nxt = 1'b1;
          den_nxt = 1'b1;
          br_nxt = !i_more_pending;
          if (i_virtual_mode) begin
            as_nxt = 1'b1; // strobe negated in virtual phase
            state_nxt = bus_seq_pkg::ST_VA;
          end else begin
            as_nxt = 1'b0;
            state_nxt = bus_seq_pkg::ST_PA;
          end
        end
      end
      bus_seq_pkg::ST_VA: begin
        // virtual address held one clock, then released for the MMU
        adoe_nxt = 1'b0;
        state_nxt = bus_seq_pkg::ST_MMU;
      end
      bus_seq_pkg::ST_MMU: begin
        as_nxt = 1'b0;
        state_nxt = bus_seq_pkg::ST_PA; // muxed lines stay undriven
      end
      bus_seq_pkg::ST_PA: begin
        den_nxt = 1'b0;
        if (!cur_r.burst || i_strobe_early_negate || left_r == 4'h1) begin
          as_nxt = 1'b1;
        end
        if (!cur_r.read) begin
          ad_nxt = i_wr_data;
          adoe_nxt = 1'b1;
          take_nxt = 1'b1;
        end else begin
          adoe_nxt = 1'b0;
        end
        state_nxt = bus_seq_pkg::ST_DATA;
      end
      bus_seq_pkg::ST_DATA: begin
        if (retry) begin
          state_nxt = bus_seq_pkg::ST_REC; // rerun after recovery
          first_nxt = 1'b0;
        end else if (ack || err) begin // wait otherwise
          if (cur_r.read && ack) begin
            rd_nxt = i_muxed_addr_data_lines;
            rdv_nxt = 1'b1;
          end
          if (last || err) begin
            state_nxt = bus_seq_pkg::ST_REC;
            done_nxt = 1'b1;
            err_nxt = err;
            first_nxt = 1'b1;
          end else begin
            left_nxt = left_r - 4'h1;
            addr_nxt = addr_r + bus_seq_pkg::WORD_STEP;
            if (left_r == 4'h2 && !i_strobe_early_negate) begin
              as_nxt = 1'b1;
            end
            if (!cur_r.read) begin
              ad_nxt = i_wr_data;
              take_nxt = 1'b1;
            end
          end
        end
      end
      bus_seq_pkg::ST_REC: begin
        // negated controls stop being driven after the recovery clock
        coe_nxt = 1'b0;
        if (!first_r) begin
          br_nxt = 1'b0; // retry keeps current transaction
          broe_nxt = 1'b1;
          state_nxt = bus_seq_pkg::ST_REQ;
        end else begin
          br_nxt = 1'b1;
          broe_nxt = 1'b0;
          state_nxt = bus_seq_pkg::ST_IDLE;
        end
      end
      default: state_nxt = bus_seq_pkg::ST_IDLE;
    endcase
    // recovery already shows negated controls, else the slave sees one more data phase
    if (state_nxt == bus_seq_pkg::ST_REC) begin
      rw_nxt = 1'b0;
      den_nxt = 1'b1;
      siz_nxt = bus_seq_pkg::SIZE_SINGLE;
      aoe_nxt = 1'b0;
      adoe_nxt = 1'b0;
      asoe_nxt = 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      state_r <= bus_seq_pkg::ST_IDLE;
      cur_r <= '0;
      left_r <= 4'h0;
      first_r <= 1'b1;
      addr_r <= '0;
      ad_r <= '0;
      rd_r <= '0;
      br_r <= 1'b1;
      as_r <= 1'b1;
      den_r <= 1'b1;
      rw_r <= 1'b0;
      siz_r <= bus_seq_pkg::SIZE_SINGLE;
      aoe_r <= 1'b0;
      adoe_r <= 1'b0;
      asoe_r <= 1'b0;
      coe_r <= 1'b0;
      broe_r <= 1'b0;
      rdv_r <= 1'b0;
      done_r <= 1'b0;
      err_r <= 1'b0;
      rdy_r <= 1'b0;
      take_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cur_r <= cur_nxt;
      left_r <= left_nxt;
      first_r <= first_nxt;
      addr_r <= addr_nxt;
      ad_r <= ad_nxt;
      rd_r <= rd_nxt;
      br_r <= br_nxt;
      as_r <= as_nxt;
      den_r <= den_nxt;
      rw_r <= rw_nxt;
      siz_r <= siz_nxt;
      aoe_r <= aoe_nxt;
      adoe_r <= adoe_nxt;
      asoe_r <= asoe_nxt;
      coe_r <= coe_nxt;
      broe_r <= broe_nxt;
      rdv_r <= rdv_nxt;
      done_r <= done_nxt;
      err_r <= err_nxt;
      rdy_r <= rdy_nxt;
      take_r <= take_nxt;
    end
  end

  assign o_req_ready = rdy_r;
  assign o_wr_data_take = take_r;
  assign o_rd_valid = rdv_r;
  assign o_rd_data = rd_r;
  assign o_done = done_r;
  assign o_error = err_r;
  assign o_bus_request_n = br_r;
  assign o_bus_request_n_oe = broe_r;
  assign o_upper_address_lines = addr_r;
  assign o_upper_address_lines_oe = aoe_r;
  assign o_muxed_addr_data_lines = ad_r;
  assign o_muxed_addr_data_lines_oe = adoe_r;
  assign o_address_strobe_n = as_r;
  assign o_address_strobe_n_oe = asoe_r;
  assign o_read_not_write = rw_r;
  assign o_transfer_size = siz_r;
  assign o_data_enable_n = den_r;
  assign o_ctrl_oe = coe_r;

  a_grant_gate: assert property (@(posedge i_clk) disable iff (!i_nrst)
    state_r == bus_seq_pkg::ST_REQ && !grant |=> state_r == bus_seq_pkg::ST_REQ)
    else $error("left request phase without grant");
  a_phys_bound: assert property (@(posedge i_clk) disable iff (!i_nrst)
    state_r == bus_seq_pkg::ST_REQ && grant && !i_virtual_mode
    |-> ##[1:3] state_r == bus_seq_pkg::ST_PA)
    else $error("physical address phase late");
  a_virt_bound: assert property (@(posedge i_clk) disable iff (!i_nrst)
    state_r == bus_seq_pkg::ST_REQ && grant && i_virtual_mode
    |-> ##[1:3] state_r == bus_seq_pkg::ST_VA)
    else $error("virtual address phase late");
  a_pa_drive: assert property (@(posedge i_clk) disable iff (!i_nrst)
    state_r == bus_seq_pkg::ST_PA && !i_virtual_mode
    |-> !o_address_strobe_n && o_muxed_addr_data_lines_oe && o_upper_address_lines_oe)
    else $error("physical address phase not driven");
  a_va_one: assert property (@(posedge i_clk) disable iff (!i_nrst)
    state_r == bus_seq_pkg::ST_VA |-> o_address_strobe_n
    ##1 state_r == bus_seq_pkg::ST_MMU ##1 !o_muxed_addr_data_lines_oe)
    else $error("virtual phase wrong");
  a_wait_hold: assert property (@(posedge i_clk) disable iff (!i_nrst)
    state_r == bus_seq_pkg::ST_DATA && !ack && !err && !retry
    |=> state_r == bus_seq_pkg::ST_DATA && $stable(left_r))
    else $error("data phase left without acknowledge");
  a_burst_addr: assert property (@(posedge i_clk) disable iff (!i_nrst)
    state_r == bus_seq_pkg::ST_DATA && ack && !err && !retry && !last
    |=> o_upper_address_lines == $past(o_upper_address_lines) + bus_seq_pkg::WORD_STEP)
    else $error("burst address not advanced");
  a_rd_latch: assert property (@(posedge i_clk) disable iff (!i_nrst)
    o_rd_valid |-> $past(ack) && $past(state_r) == bus_seq_pkg::ST_DATA)
    else $error("read data latched without acknowledge");
  a_idle_free: assert property (@(posedge i_clk) disable iff (!i_nrst)
    state_r == bus_seq_pkg::ST_IDLE && $past(state_r) == bus_seq_pkg::ST_IDLE
    |-> !o_ctrl_oe && !o_muxed_addr_data_lines_oe && !o_address_strobe_n_oe)
    else $error("bus driven while idle");
  a_retry_rerun: assert property (@(posedge i_clk) disable iff (!i_nrst)
    state_r == bus_seq_pkg::ST_DATA && retry
    |=> state_r == bus_seq_pkg::ST_REC ##1 state_r == bus_seq_pkg::ST_REQ)
    else $error("retry not rerun");
  a_rec_negate: assert property (@(posedge i_clk) disable iff (!i_nrst)
    state_r == bus_seq_pkg::ST_REC
    |-> o_data_enable_n && !o_muxed_addr_data_lines_oe && !o_upper_address_lines_oe)
    else $error("recovery phase still drives the bus");
  c_burst_done: cover property (@(posedge i_clk) disable iff (!i_nrst)
    o_done && cur_r.burst8);
  c_virt_read: cover property (@(posedge i_clk) disable iff (!i_nrst)
    o_rd_valid && i_virtual_mode);
  c_retry: cover property (@(posedge i_clk) disable iff (!i_nrst)
    state_r == bus_seq_pkg::ST_DATA && retry);
endmodule : system_bus_master_sequencer

// ---- rtl/bus_seq_pkg.sv ----
// package: constants, states and carriers of the system bus master sequencer
package bus_seq_pkg;
  localparam int ADDR_W = 32;
  localparam int DATA_W = 32;
  localparam int SIZE_W = 3;
  // grant-to-address-phase bound, in clocks
  localparam int GRANT_TO_ADDR_MAX = 3;
  localparam logic [3:0] BURST_SHORT = 4'h4;
  localparam logic [3:0] BURST_LONG = 4'h8;
  localparam logic [ADDR_W-1:0] WORD_STEP = 32'h0000_0004;
  // transfer size codes driven on transfer_size
  localparam logic [SIZE_W-1:0] SIZE_SINGLE = 3'h0;
  localparam logic [SIZE_W-1:0] SIZE_BURST4 = 3'h4;
  localparam logic [SIZE_W-1:0] SIZE_BURST8 = 3'h5;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_REQ  = 3'b001,
    ST_VA   = 3'b010,
    ST_MMU  = 3'b011,
    ST_PA   = 3'b100,
    ST_DATA = 3'b101,
    ST_REC  = 3'b110
  } seq_state_t;

  // user-side transaction request
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic read;
    logic burst;
    logic burst8;
  } xfer_req_t;

  // pin-side inputs from arbiter and slave
  typedef struct packed {
    logic bus_grant_n;
    logic slave_acknowledge_n;
    logic slave_error_n;
    logic retry_n;
  } bus_in_t;
endpackage : bus_seq_pkg

// ---- tb/bus_partner_model.sv ----
// partner model: host arbiter, host mmu and memory slave of the system bus
`timescale 1ns/10ps
module bus_partner_model (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic [3:0] i_waits,
  input wire logic i_err,
  input wire logic i_retry,
  input wire logic i_bus_request_n,
  input wire logic i_bus_request_n_oe,
  input wire logic i_address_strobe_n,
  input wire logic i_data_enable_n,
  input wire logic i_read_not_write,
  input wire logic i_ctrl_oe,
  input wire logic [31:0] i_addr,
  input wire logic [31:0] i_ad_wire,
  input wire logic i_ad_oe,
  output bus_seq_pkg::bus_in_t o_bus,
  output logic [31:0] o_ad
);
  logic [3:0] wc;
  logic retried;
  logic [31:0] va;
  logic [31:0] cap [0:15];
  int cap_n;

  always @(negedge i_clk) begin
    if (!i_nrst) begin
      o_bus <= 4'hF;
      o_ad <= 32'h0;
      wc <= 4'h0;
      retried <= 1'b0;
    end else begin
      if (i_bus_request_n_oe && !i_bus_request_n) begin
        o_bus.bus_grant_n <= 1'b0;
      end else if (!i_ctrl_oe) begin
        o_bus.bus_grant_n <= 1'b1;
      end
      o_bus.slave_acknowledge_n <= 1'b1;
      o_bus.slave_error_n <= 1'b1;
      o_bus.retry_n <= 1'b1;
      // released lines toggle so a stale word never looks valid
      o_ad <= ~o_ad;
      if (i_ctrl_oe && i_ad_oe && i_address_strobe_n && i_data_enable_n) begin
        va <= i_ad_wire;
      end
      if (i_ctrl_oe && !i_ad_oe && !i_address_strobe_n && i_data_enable_n) begin
        o_ad <= va ^ 32'h0F00_0000;
      end
      if (!i_ctrl_oe || i_data_enable_n) begin
        wc <= 4'h0;
      end else if (wc != i_waits) begin
        wc <= wc + 4'h1;
      end else begin
        wc <= 4'h0;
        if (i_retry && !retried) begin
          o_bus.retry_n <= 1'b0;
          retried <= 1'b1;
        end else begin
          o_bus.slave_acknowledge_n <= 1'b0;
          o_bus.slave_error_n <= !i_err;
          o_ad <= {i_addr[15:0], ~i_addr[31:16]};
        end
      end
      if (!i_retry) begin
        retried <= 1'b0;
      end
    end
  end

  always @(posedge i_clk) begin
    if (!i_ctrl_oe && i_bus_request_n_oe && !i_bus_request_n) begin
      cap_n <= 0;
    end else if (i_ctrl_oe && !i_data_enable_n && !i_read_not_write
                 && !o_bus.slave_acknowledge_n) begin
      cap[cap_n[3:0]] <= i_ad_wire;
      cap_n <= cap_n + 1;
    end
  end
endmodule : bus_partner_model

// ---- tb/system_bus_master_sequencer_tb_top.sv ----
// testbench top of the system bus master sequencer
`timescale 1ns/10ps
module system_bus_master_sequencer_tb_top;
  logic clk, nrst, vmode, early, req_valid, more, err_in, retry_in, err_seen, br_prev, rwq, brq;
  logic req_ready, take, rd_valid, done, err, br_n, br_oe, ua_oe, ad_oe, as_n, as_oe;
  logic rw, den_n, ctrl_oe;
  bus_seq_pkg::xfer_req_t req;
  bus_seq_pkg::bus_in_t bus;
  logic [31:0] wr_data, ad_wire, ad_part, rd_data, ua, ad_out;
  logic [2:0] size, szq;
  logic [3:0] waits;
  logic [31:0] rdq [0:15];
  int n_fail, num_checks, nrd, nwr, ndone, novl, nva, npa, nbr;

  assign ad_wire = ad_oe ? ad_out : ad_part;
  assign wr_data = 32'hC0DE_0000 + 32'(nwr);

  system_bus_master_sequencer i_system_bus_master_sequencer (
    .i_clk(clk), .i_nrst(nrst), .i_virtual_mode(vmode), .i_strobe_early_negate(early),
    .i_req_valid(req_valid), .i_req(req), .i_more_pending(more), .i_wr_data(wr_data),
    .i_bus(bus), .i_muxed_addr_data_lines(ad_wire), .o_req_ready(req_ready),
    .o_wr_data_take(take), .o_rd_valid(rd_valid), .o_rd_data(rd_data), .o_done(done),
    .o_error(err), .o_bus_request_n(br_n), .o_bus_request_n_oe(br_oe),
    .o_upper_address_lines(ua), .o_upper_address_lines_oe(ua_oe),
    .o_muxed_addr_data_lines(ad_out), .o_muxed_addr_data_lines_oe(ad_oe),
    .o_address_strobe_n(as_n), .o_address_strobe_n_oe(as_oe), .o_read_not_write(rw),
    .o_transfer_size(size), .o_data_enable_n(den_n), .o_ctrl_oe(ctrl_oe));

  bus_partner_model i_bus_partner_model (
    .i_clk(clk), .i_nrst(nrst), .i_waits(waits), .i_err(err_in), .i_retry(retry_in),
    .i_bus_request_n(br_n), .i_bus_request_n_oe(br_oe), .i_address_strobe_n(as_n),
    .i_data_enable_n(den_n), .i_read_not_write(rw), .i_ctrl_oe(ctrl_oe), .i_addr(ua),
    .i_ad_wire(ad_wire), .i_ad_oe(ad_oe), .o_bus(bus), .o_ad(ad_part));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  always @(negedge clk) begin
    if (take) nwr++;
  end

  always @(posedge clk) begin
    if (rd_valid) begin
      rdq[nrd[3:0]] = rd_data;
      nrd++;
    end
    if (ctrl_oe && !as_n && !den_n) novl++;
    if (ctrl_oe && ad_oe && as_n && den_n) nva++;
    if (ctrl_oe && ad_oe && !as_n && den_n) npa++;
    if (ctrl_oe && !as_n && den_n) begin
      szq = size;
      rwq = rw;
      brq = br_n;
    end
    if (br_oe && !br_n && br_prev) nbr++;
    br_prev = br_n | !br_oe;
    if (done) begin
      ndone++;
      err_seen = err;
    end
  end

  task automatic final_report;
    if (n_fail == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : final_report

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  function automatic logic [31:0] mem_word(input logic [31:0] a);
    return {a[15:0], ~a[31:16]};
  endfunction : mem_word

  task automatic run(input logic [31:0] a, input logic rd, b, b8, input logic [3:0] w,
                     input logic e, r);
    int i;
    @(negedge clk);
    {nrd, nwr, ndone, novl, nva, npa, nbr} = 224'h0;
    waits = w;
    err_in = e;
    retry_in = r;
    req = {a, rd, b, b8};
    req_valid = 1'b1;
    for (i = 0; i < 50 && br_n !== 1'b0; i++) @(negedge clk);
    if (i >= 50) begin
      n_fail++;
      final_report();
    end
    req_valid = 1'b0;
    for (i = 0; i < 400 && ndone == 0; i++) @(negedge clk);
    if (i >= 400) begin
      n_fail++;
      final_report();
    end
    repeat (2) @(negedge clk);
    check("idle oe", 32'h0, 32'({br_oe, ua_oe, ad_oe, as_oe, ctrl_oe}));
    check("ready", 32'h1, 32'(req_ready));
    retry_in = 1'b0;
  endtask : run

  task automatic t_single(input logic rd, virt, input logic [3:0] w);
    vmode = virt;
    run(32'h1000_0040, rd, 1'b0, 1'b0, w, 1'b0, 1'b0);
    if (rd) check("rd word", mem_word(32'h1000_0040), rdq[0]);
    else check("wr word", 32'hC0DE_0000, i_bus_partner_model.cap[0]);
    check("words", 32'h1, rd ? 32'(nrd) : 32'(i_bus_partner_model.cap_n));
    check("strobe overlap", 32'h0, 32'(novl));
    check("va cycles", 32'(virt), 32'(nva));
    check("pa drive", 32'(!virt), 32'(npa));
    check("request dropped", 32'h1, 32'(brq));
    check("size rw err", {27'h0, bus_seq_pkg::SIZE_SINGLE, rd, 1'b0},
          {27'h0, szq, rwq, err_seen});
  endtask : t_single

  task automatic t_burst(input logic rd, b8, ea, input logic [3:0] w);
    int n, j;
    n = b8 ? 8 : 4;
    early = ea;
    vmode = 1'b0;
    run(32'h2000_0100, rd, 1'b1, b8, w, 1'b0, 1'b0);
    for (j = 0; j < n; j++) begin
      if (rd) check("burst rd", mem_word(32'h2000_0100 + 32'(4 * j)), rdq[j]);
      else check("burst wr", 32'hC0DE_0000 + 32'(j), i_bus_partner_model.cap[j]);
    end
    check("burst words", 32'(n), rd ? 32'(nrd) : 32'(i_bus_partner_model.cap_n));
    if (w == 4'h0) check("burst overlap", ea ? 32'h0 : 32'(n - 1), 32'(novl));
    check("burst size", {29'h0, b8 ? bus_seq_pkg::SIZE_BURST8 : bus_seq_pkg::SIZE_BURST4},
          {29'h0, szq});
  endtask : t_burst

  task automatic t_error_retry;
    vmode = 1'b0;
    more = 1'b1;
    run(32'h3000_0000, 1'b1, 1'b0, 1'b0, 4'h1, 1'b1, 1'b0);
    more = 1'b0;
    check("error", 32'h1, 32'(err_seen));
    check("request kept", 32'h0, 32'(brq));
    run(32'h4000_0080, 1'b1, 1'b0, 1'b0, 4'h1, 1'b0, 1'b1);
    check("retry word", mem_word(32'h4000_0080), rdq[0]);
    check("retry reads", 32'h1, 32'(nrd));
    check("retry requests", 32'h2, 32'(nbr));
  endtask : t_error_retry

  initial begin
    int k;
    {nrst, vmode, early, req_valid, more, err_in, retry_in} = 7'h00;
    req = '0;
    waits = 4'h0;
    br_prev = 1'b1;
    repeat (16) @(negedge clk);
    nrst = 1'b1;
    check("reset oe", 32'h0, 32'({br_oe, ua_oe, ad_oe, as_oe, ctrl_oe}));
    t_single(1'b1, 1'b0, 4'h2);
    t_single(1'b0, 1'b0, 4'h1);
    t_single(1'b1, 1'b1, 4'h0);
    t_single(1'b0, 1'b1, 4'h3);
    for (k = 0; k < 8; k++) t_burst(k[0], k[1], k[2], 4'h0);
    t_burst(1'b1, 1'b1, 1'b0, 4'h2);
    t_burst(1'b0, 1'b0, 1'b1, 4'h1);
    t_error_retry();
    final_report();
  end
endmodule : system_bus_master_sequencer_tb_top
